// ==== pir_agents.sv ====
module pir_agents (
  input  wire logic [3:0] raise_slot,   // Slot agents asking for service, A..D
  input  wire logic [3:0] raise_board,  // On-board agents asking, A..D
  input  wire logic       raise_aux0,   // Auxiliary source 0 asking
  input  wire logic       raise_aux1,   // Auxiliary source 1 asking
  output logic      [3:0] slot_int_n,   // Slot pins, active low
  output logic      [3:0] board_int_n,  // Board lines, active low
  output logic            aux0_n,       // Auxiliary 0, active low
  output logic            aux1          // Auxiliary 1, active high
);
  timeunit 1ns;
  timeprecision 1ps;
  // Lines are driven push-pull: idle agents drive the active-low lines high
  assign slot_int_n  = ~raise_slot;
  assign board_int_n = ~raise_board;
  assign aux0_n      = ~raise_aux0;
  assign aux1        = raise_aux1;
endmodule : pir_agents

// ==== pir_pkg.sv ====
// Functional notes
// [RULE_01] Four active-low PCI interrupt lines are accepted
// [RULE_02] Slot D,A,B,C pins feed board A,B,C,D
// [RULE_03] One board line reaches one IRQ
// [RULE_04] Code gives IRQ number; 0,2,8,13 reserved
// [RULE_05] First register: INTD high, aux 0 low
// [RULE_06] Second register: INTA high, INTB low
// [RULE_07] Third register: INTC high, aux 1 low
// [RULE_08] All routing registers reset to zero
// [RULE_09] Firmware programs routing; software may rewrite later
// [RULE_10] Reserved code disconnects; shared IRQs are ORed
// [RULE_11] Writes land on that edge; reads unchanged
package pir_pkg;

  // Configuration-space byte offsets of the routing registers
  localparam logic [7:0] PIR_OFS_STEER_D_AUX0 = 8'h55;
  localparam logic [7:0] PIR_OFS_STEER_A_B    = 8'h56;
  localparam logic [7:0] PIR_OFS_STEER_C_AUX1 = 8'h57;

  // Reset value of every routing register
  localparam logic [7:0] PIR_STEER_RESET = 8'h00;

  // Field positions inside a routing register
  localparam int PIR_HI_LSB   = 4;
  localparam int PIR_LO_LSB   = 0;
  localparam int PIR_CODE_W   = 4;
  localparam int PIR_IRQ_NUM  = 16;
  localparam int PIR_LINE_NUM = 4;

  // Reserved steering codes
  localparam logic [3:0] PIR_CODE_RSV0 = 4'h0;
  localparam logic [3:0] PIR_CODE_RSV2 = 4'h2;
  localparam logic [3:0] PIR_CODE_RSV8 = 4'h8;
  localparam logic [3:0] PIR_CODE_RSVD = 4'hD;

  // Board line indices
  localparam int PIR_LINE_A = 0;
  localparam int PIR_LINE_B = 1;
  localparam int PIR_LINE_C = 2;
  localparam int PIR_LINE_D = 3;

  // One configuration access, as presented by the bridge front end
  typedef struct packed {
    logic       wr;    // Write strobe, one cycle
    logic       rd;    // Read strobe, one cycle
    logic [7:0] addr;  // Byte offset in configuration space
    logic [7:0] wdata; // Write byte
  } pir_cfg_req_s;

endpackage : pir_pkg

// ==== pir_router.sv ====
module pir_router (
  input  wire logic                 clk_sys,           // Bus clock, 25 MHz
  input  wire logic                 rst_n,             // Async reset, active low
  input  wire pir_pkg::pir_cfg_req_s cfg_req,          // Configuration access
  output logic [7:0]                cfg_rdata,         // Read data, one cycle after rd
  output logic                      cfg_rvalid,        // Read data valid pulse
  input  wire logic [3:0]           board_int_n,       // On-board agents, A..D, active low
  input  wire logic [3:0]           slot_int_n,        // Slot pins A..D, active low
  input  wire logic                 aux_interrupt_in0_n, // Auxiliary input 0, active low
  input  wire logic                 aux_interrupt_in1, // Auxiliary input 1, active high
  output logic [15:0]               irq_out            // AT IRQ lines, active high
);

  // Routing registers
  logic [7:0]  irq_steer_d_aux0;  // INTD / aux 0 codes
  logic [7:0]  irq_steer_a_b;     // INTA / INTB codes
  logic [7:0]  irq_steer_c_aux1;  // INTC / aux 1 codes
  logic [7:0]  next_steer_d_aux0; // Next values
  logic [7:0]  next_steer_a_b;
  logic [7:0]  next_steer_c_aux1;
  logic [7:0]  next_rdata;        // Next read data
  logic        next_rvalid;       // Next read-valid
  logic [15:0] next_irq;          // Next IRQ image

  // Combined board lines, active high
  logic [3:0]  line_act;

  // Decode a steering code into a one-hot IRQ mask; reserved codes give none
  function automatic logic [15:0] pir_decode(input logic [3:0] code);
    logic [15:0] mask;
    mask = '0;
    if (code != pir_pkg::PIR_CODE_RSV0 && code != pir_pkg::PIR_CODE_RSV2 &&
        code != pir_pkg::PIR_CODE_RSV8 && code != pir_pkg::PIR_CODE_RSVD) begin // RULE_10
      mask[code] = 1'b1; // RULE_04
    end
    return mask;
  endfunction : pir_decode

  // Wire-AND of the shared lines: slot pins are rotated onto board lines
  always_comb begin
    line_act[pir_pkg::PIR_LINE_A] = ~board_int_n[0] | ~slot_int_n[3]; // RULE_02
    line_act[pir_pkg::PIR_LINE_B] = ~board_int_n[1] | ~slot_int_n[0]; // RULE_02
    line_act[pir_pkg::PIR_LINE_C] = ~board_int_n[2] | ~slot_int_n[1]; // RULE_02
    line_act[pir_pkg::PIR_LINE_D] = ~board_int_n[3] | ~slot_int_n[2]; // RULE_02 RULE_01
  end

  // Register write and read path
  always_comb begin
    next_steer_d_aux0 = irq_steer_d_aux0;
    next_steer_a_b    = irq_steer_a_b;
    next_steer_c_aux1 = irq_steer_c_aux1;
    next_rdata        = 8'h00;
    next_rvalid       = cfg_req.rd;
    // Writes land on the edge that takes the strobe
    if (cfg_req.wr) begin
      unique case (cfg_req.addr)
        pir_pkg::PIR_OFS_STEER_D_AUX0: next_steer_d_aux0 = cfg_req.wdata; // RULE_11
        pir_pkg::PIR_OFS_STEER_A_B:    next_steer_a_b    = cfg_req.wdata; // RULE_11
        pir_pkg::PIR_OFS_STEER_C_AUX1: next_steer_c_aux1 = cfg_req.wdata; // RULE_11
        default: ;  // Other offsets belong to other bridge functions
      endcase
    end
    // Reads return the stored byte; other offsets read zero
    if (cfg_req.rd) begin
      unique case (cfg_req.addr)
        pir_pkg::PIR_OFS_STEER_D_AUX0: next_rdata = irq_steer_d_aux0; // RULE_11
        pir_pkg::PIR_OFS_STEER_A_B:    next_rdata = irq_steer_a_b;
        pir_pkg::PIR_OFS_STEER_C_AUX1: next_rdata = irq_steer_c_aux1;
        default:                       next_rdata = 8'h00;
      endcase
    end
  end

  // Register the configuration state
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_steer_d_aux0 <= pir_pkg::PIR_STEER_RESET; // RULE_08
      irq_steer_a_b    <= pir_pkg::PIR_STEER_RESET; // RULE_08
      irq_steer_c_aux1 <= pir_pkg::PIR_STEER_RESET; // RULE_08
      cfg_rdata        <= 8'h00;
      cfg_rvalid       <= 1'b0;
    end else begin
      irq_steer_d_aux0 <= next_steer_d_aux0;
      irq_steer_a_b    <= next_steer_a_b;
      irq_steer_c_aux1 <= next_steer_c_aux1;
      cfg_rdata        <= next_rdata;
      cfg_rvalid       <= next_rvalid;
    end
  end

  // Steering: each source picks at most one IRQ; shared IRQs are ORed.
  // The output is registered, which costs one cycle of latency but keeps
  // glitches of the decode away from the interrupt controller.
  always_comb begin
    next_irq = '0;
    if (line_act[pir_pkg::PIR_LINE_D])
      next_irq = next_irq | pir_decode(irq_steer_d_aux0[7:4]); // RULE_05
    if (!aux_interrupt_in0_n)
      next_irq = next_irq | pir_decode(irq_steer_d_aux0[3:0]); // RULE_05
    if (line_act[pir_pkg::PIR_LINE_A])
      next_irq = next_irq | pir_decode(irq_steer_a_b[7:4]);    // RULE_06
    if (line_act[pir_pkg::PIR_LINE_B])
      next_irq = next_irq | pir_decode(irq_steer_a_b[3:0]);    // RULE_06
    if (line_act[pir_pkg::PIR_LINE_C])
      next_irq = next_irq | pir_decode(irq_steer_c_aux1[7:4]); // RULE_07
    if (aux_interrupt_in1)
      next_irq = next_irq | pir_decode(irq_steer_c_aux1[3:0]); // RULE_07
  end

  // Register the IRQ image
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_out <= '0;           // RULE_08
    end else begin
      irq_out <= next_irq;     // RULE_03 RULE_10
    end
  end

  // Reserved IRQ positions can never be driven
  AST_RSV_NEVER: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_04
    (irq_out[0] | irq_out[2] | irq_out[8] | irq_out[13]) == 1'b0)
    else $error("Reserved IRQ asserted");

  // Write to the first register shows on read two cycles later
  AST_WR_D_AUX0: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_11
    cfg_req.wr && cfg_req.addr == 8'h55 ##1 (cfg_req.rd && !cfg_req.wr && cfg_req.addr == 8'h55)
    |=> cfg_rvalid && cfg_rdata == $past(cfg_req.wdata, 2))
    else $error("Routing write not read back");

  // Unmapped reads return zero
  AST_UNMAPPED: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_11
    cfg_req.rd && !(cfg_req.addr inside {8'h55, 8'h56, 8'h57}) |=> cfg_rdata == 8'h00)
    else $error("Unmapped read not zero");

  // With all registers at zero nothing is routed
  AST_RESET_QUIET: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_08
    $past(irq_steer_d_aux0) == 8'h00 && $past(irq_steer_a_b) == 8'h00 &&
    $past(irq_steer_c_aux1) == 8'h00 |-> irq_out == 16'h0000)
    else $error("IRQ driven while routing disabled");

  // Slot pin D raises the IRQ chosen for board line A
  AST_ROT_SLOT_D: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_02
    !slot_int_n[3] && irq_steer_a_b[7:4] == 4'h9 |=> irq_out[9])
    else $error("Slot D not rotated onto board A");

  // Slot pin A raises the IRQ chosen for board line B
  AST_ROT_SLOT_A: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_02
    !slot_int_n[0] && irq_steer_a_b[3:0] == 4'hA |=> irq_out[10])
    else $error("Slot A not rotated onto board B");

  // On-board agent and slot on one line land on the same IRQ
  AST_SHARED_LINE: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_03
    (!board_int_n[2] || !slot_int_n[1]) && irq_steer_c_aux1[7:4] == 4'hB |=> irq_out[11])
    else $error("Shared board line C lost");

  // Aux input 0 follows the low nibble of the first register
  AST_AUX0: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_05
    !aux_interrupt_in0_n && irq_steer_d_aux0[3:0] == 4'h5 |=> irq_out[5])
    else $error("Aux 0 not routed");

  // Aux input 1 follows the low nibble of the third register
  AST_AUX1: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_07
    aux_interrupt_in1 && irq_steer_c_aux1[3:0] == 4'hF |=> irq_out[15])
    else $error("Aux 1 not routed");

  // Inactive sources cannot hold an IRQ up
  AST_IDLE_CLEAR: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_10
    (&board_int_n) && (&slot_int_n) && aux_interrupt_in0_n && !aux_interrupt_in1
    |=> irq_out == 16'h0000)
    else $error("IRQ held without a source");

  // Every read strobe gives exactly one valid pulse on the next edge
  AST_RVALID_ON: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_11
    cfg_req.rd |=> cfg_rvalid)
    else $error("Read strobe gave no valid pulse");

  // Without a read the data bus rests at zero, so stale bytes never leak out
  AST_RVALID_OFF: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_11
    !cfg_req.rd |=> !cfg_rvalid && cfg_rdata == 8'h00)
    else $error("Read data or valid without a strobe");

  // Second register reads back its stored byte unchanged
  AST_RD_A_B: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_06
    cfg_req.rd && cfg_req.addr == pir_pkg::PIR_OFS_STEER_A_B
    |=> cfg_rdata == $past(irq_steer_a_b))
    else $error("Second routing register read wrong");

  // Third register reads back its stored byte unchanged
  AST_RD_C_AUX1: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_07
    cfg_req.rd && cfg_req.addr == pir_pkg::PIR_OFS_STEER_C_AUX1
    |=> cfg_rdata == $past(irq_steer_c_aux1))
    else $error("Third routing register read wrong");

  // A write lands on the very edge that takes it
  AST_WR_LAND: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_11
    cfg_req.wr && cfg_req.addr == pir_pkg::PIR_OFS_STEER_A_B
    |=> irq_steer_a_b == $past(cfg_req.wdata))
    else $error("Routing write did not land");

  // Writes to neighbouring offsets belong to other functions and must not touch routing
  AST_WR_IGNORED: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_11
    cfg_req.wr && !(cfg_req.addr inside {8'h55, 8'h56, 8'h57})
    |=> $stable(irq_steer_d_aux0) && $stable(irq_steer_a_b) && $stable(irq_steer_c_aux1))
    else $error("Unmapped write changed routing");

  // Slot pin B raises the IRQ chosen for board line C
  AST_ROT_SLOT_B: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_02
    !slot_int_n[1] && irq_steer_c_aux1[7:4] == 4'hC |=> irq_out[12])
    else $error("Slot B not rotated onto board C");

  // Slot pin C raises the IRQ chosen for board line D
  AST_ROT_SLOT_C: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_02
    !slot_int_n[2] && irq_steer_d_aux0[7:4] == 4'h9 |=> irq_out[9])
    else $error("Slot C not rotated onto board D");

  // An on-board agent on line A reaches the IRQ chosen for that line
  AST_BOARD_A: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_01
    !board_int_n[0] && irq_steer_a_b[7:4] == 4'hA |=> irq_out[10])
    else $error("Board line A not routed");

endmodule : pir_router

// ==== tb.sv ====
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  clk_sys = 1'b0; // Bus clock
  logic                  rst_n = 1'b0;   // System reset
  pir_pkg::pir_cfg_req_s req = '0;       // Configuration access
  logic [7:0]            rdata;          // Read byte
  logic                  rvalid;         // Read valid
  logic [3:0]            rs = 4'h0;      // Slot raise requests
  logic [3:0]            rb = 4'h0;      // Board raise requests
  logic                  ra0 = 1'b0;     // Aux 0 raise
  logic                  ra1 = 1'b0;     // Aux 1 raise
  logic [3:0]            slot_n;         // Slot pins
  logic [3:0]            board_n;        // Board lines
  logic                  aux0_n;         // Aux 0 pin
  logic                  aux1;           // Aux 1 pin
  logic [15:0]           irq;            // AT IRQ lines
  int                    failures = 0;   // Mismatches
  int                    check_count = 0; // Comparisons
  pir_agents AGT (.raise_slot(rs), .raise_board(rb), .raise_aux0(ra0), .raise_aux1(ra1),
    .slot_int_n(slot_n), .board_int_n(board_n), .aux0_n(aux0_n), .aux1(aux1));
  pir_router DUT (.clk_sys(clk_sys), .rst_n(rst_n), .cfg_req(req), .cfg_rdata(rdata),
    .cfg_rvalid(rvalid), .board_int_n(board_n), .slot_int_n(slot_n),
    .aux_interrupt_in0_n(aux0_n), .aux_interrupt_in1(aux1), .irq_out(irq));
  // 25 MHz clock
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  // Shared compare, four-state safe
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    req.wr = 1'b1; req.addr = a; req.wdata = d;
    @(negedge clk_sys);
    req.wr = 1'b0;
  endtask : wr
  // Read; valid and data are judged in the one cycle that they stand
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_sys);
    req.rd = 1'b1; req.addr = a;
    @(negedge clk_sys);
    req.rd = 1'b0;
    // Valid was launched at the edge that took the strobe and stands until the next one
    chk({7'h0, rvalid, rdata}, {8'h01, exp});
  endtask : rd
  // Raise sources, let the registered output settle, compare
  task automatic ic(input logic [3:0] s, input logic [3:0] b, input logic [1:0] x,
                    input logic [15:0] exp);
    @(negedge clk_sys);
    rs = s; rb = b; {ra1, ra0} = x;
    repeat (2) @(negedge clk_sys);
    chk(irq, exp);
  endtask : ic
  task automatic test_reset;
    rd(8'h55, 8'h00);
    rd(8'h56, 8'h00);
    rd(8'h57, 8'h00);
    ic(4'hF, 4'hF, 2'h3, 16'h0000);
    $display("test_reset done");
  endtask : test_reset
  task automatic test_regs;
    wr(8'h55, 8'hA5); wr(8'h56, 8'h5A); wr(8'h57, 8'hC3); wr(8'h54, 8'hFF);
    rd(8'h55, 8'hA5);
    rd(8'h56, 8'h5A);
    rd(8'h57, 8'hC3);
    rd(8'h54, 8'h00); // Unmapped offset reads zero
    $display("test_regs done");
  endtask : test_regs
  task automatic test_route;
    int bit_of[4] = '{10, 11, 12, 9}; // IRQ of board lines A..D
    wr(8'h55, 8'h93); wr(8'h56, 8'hAB); wr(8'h57, 8'hCE);
    for (int i = 0; i < 4; i++) begin
      ic(4'h0, 4'h1 << i, 2'h0, 16'h1 << bit_of[i]);
      ic(4'h1 << i, 4'h0, 2'h0, 16'h1 << bit_of[(i + 1) % 4]);
    end
    ic(4'h0, 4'h0, 2'h1, 16'h0008);
    ic(4'h0, 4'h0, 2'h2, 16'h4000);
    ic(4'h1, 4'h2, 2'h0, 16'h0800);
    ic(4'h1, 4'h0, 2'h0, 16'h0800);
    ic(4'h0, 4'h0, 2'h0, 16'h0000);
    $display("test_route done");
  endtask : test_route
  task automatic test_codes;
    logic [15:0] exp;
    for (int c = 0; c < 16; c++) begin
      wr(8'h56, 8'(c << 4));
      exp = (c == 0 || c == 2 || c == 8 || c == 13) ? 16'h0000 : 16'h1 << c;
      ic(4'h0, 4'h1, 2'h0, exp);
    end
    $display("test_codes done");
  endtask : test_codes
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  // Main sequence
  initial begin
    repeat (20) @(negedge clk_sys);
    rst_n = 1'b1;
    test_reset();
    test_regs();
    test_route();
    test_codes();
    tally_and_finish();
  end
  // Watchdog, far beyond the 170 cycles the tests need
  initial begin
    #200us;
    failures++;
    tally_and_finish();
  end
endmodule : tb
